// file: src/pmw_pkg.sv
// Shared constants and types for the program memory block writer
`default_nettype none
package pmw_pkg;
  localparam int PTR_W = 22;
  localparam int PTR_LOW_W = 21;
  localparam int BYTE_W = 8;
  localparam int BLOCK_BYTES = 2;
  localparam int ODD_BIT_POS = 0;
  localparam int NSRC = 8;
  localparam logic LWE_RST = 1'b0;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [21:0] PTR_RST = 22'h000000;
  localparam logic [20:0] PTR_ONE = 21'h000001;
  typedef enum logic [1:0] {
    PMW_PTR_KEEP,
    PMW_PTR_POST_INC,
    PMW_PTR_POST_DEC,
    PMW_PTR_PRE_INC
  } pmw_ptr_mode_t;
  typedef enum logic [1:0] {
    PMW_ACT_NONE,
    PMW_ACT_NEXT,
    PMW_ACT_VEC_LOW,
    PMW_ACT_VEC_HIGH
  } pmw_action_t;
endpackage : pmw_pkg
`default_nettype wire

// file: src/pmw_ptr_update.sv
// Byte pointer update per write variant
`default_nettype none
module pmw_ptr_update
  import pmw_pkg::*;
(
  input wire logic [pmw_pkg::PTR_W-1:0] ptr_i,
  input wire pmw_pkg::pmw_ptr_mode_t mode_i,
  output logic [pmw_pkg::PTR_W-1:0] access_o,
  output logic [pmw_pkg::PTR_W-1:0] next_o
);
  import pmw_pkg::*;

  logic [PTR_LOW_W-1:0] inc;
  logic [PTR_LOW_W-1:0] dec;

  assign inc = ptr_i[PTR_LOW_W-1:0] + PTR_ONE;
  assign dec = ptr_i[PTR_LOW_W-1:0] - PTR_ONE;

  // Only the low 21 bits move; top bit stays
  always_comb begin
    access_o = ptr_i;
    next_o = ptr_i;
    case (mode_i)
      PMW_PTR_KEEP: begin
        next_o = ptr_i;
      end
      PMW_PTR_POST_INC: begin
        next_o = {ptr_i[PTR_W-1], inc};
      end
      PMW_PTR_POST_DEC: begin
        next_o = {ptr_i[PTR_W-1], dec};
      end
      PMW_PTR_PRE_INC: begin
        access_o = {ptr_i[PTR_W-1], inc};
        next_o = {ptr_i[PTR_W-1], inc};
      end
      default: begin
        next_o = ptr_i;
      end
    endcase
  end
endmodule : pmw_ptr_update
`default_nettype wire

// file: src/pmw_term_decode.sv
// Decides how a terminated long write resumes
`default_nettype none
module pmw_term_decode
  import pmw_pkg::*;
(
  input wire logic high_priority_global_enable_i,
  input wire logic low_priority_global_enable_i,
  input wire logic high_prio_i,
  output pmw_pkg::pmw_action_t action_o
);
  import pmw_pkg::*;

  always_comb begin
    action_o = PMW_ACT_NEXT;
    if (!high_priority_global_enable_i && low_priority_global_enable_i && !high_prio_i) begin
      action_o = PMW_ACT_VEC_LOW;
    end else if (high_priority_global_enable_i && !low_priority_global_enable_i
                 && high_prio_i) begin
      action_o = PMW_ACT_VEC_HIGH;
    end
  end
endmodule : pmw_term_decode
`default_nettype wire

// file: src/pmw_block_writer.sv
// Program memory block writer: short/long table writes and termination
`default_nettype none
module pmw_block_writer
  import pmw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Table write request from the core
  input wire logic table_write_instr_i,
  input wire pmw_pkg::pmw_ptr_mode_t ptr_mode_i,
  input wire logic [pmw_pkg::BYTE_W-1:0] transfer_latch_i,
  input wire logic internal_target_i,
  // Software pointer load
  input wire logic ptr_load_i,
  input wire logic [pmw_pkg::PTR_W-1:0] ptr_load_val_i,
  // Long write enable bit
  input wire logic lwe_set_i,
  input wire logic lwe_clear_i,
  // Programming-voltage qualifier
  input wire logic reset_programming_pin_vpp_i,
  // Interrupt state
  input wire logic [pmw_pkg::NSRC-1:0] irq_flag_i,
  input wire logic [pmw_pkg::NSRC-1:0] irq_enable_i,
  input wire logic [pmw_pkg::NSRC-1:0] irq_high_prio_i,
  input wire logic high_priority_global_enable_i,
  input wire logic low_priority_global_enable_i,
  // Outputs
  output logic long_write_enable_o,
  output logic [pmw_pkg::PTR_W-1:0] byte_pointer_o,
  output logic cpu_halt_o,
  output logic prog_active_o,
  output logic [pmw_pkg::PTR_W-1:0] prog_addr_o,
  output logic [2*pmw_pkg::BYTE_W-1:0] prog_data_o,
  output logic term_pulse_o,
  output pmw_pkg::pmw_action_t term_action_o
);
  import pmw_pkg::*;

  typedef enum logic {
    PMW_IDLE,
    PMW_PROG
  } pmw_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pmw_state_t state_ff;
  pmw_state_t nxt_state;
  logic lwe_ff;
  logic [BYTE_W-1:0] hold_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic [PTR_W-1:0] ptr_access;
  logic [PTR_W-1:0] ptr_next;
  logic [PTR_W-1:0] addr_ff;
  logic [2*BYTE_W-1:0] data_ff;
  logic term_ff;
  pmw_action_t action_ff;
  pmw_action_t action_dec;
  logic [NSRC-1:0] armed;
  logic [NSRC-1:0] fired;
  logic odd_addr;
  logic start_long;
  logic end_long;
  logic fired_high;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer
  pmw_ptr_update u_ptr (
    .ptr_i(ptr_ff),
    .mode_i(ptr_mode_i),
    .access_o(ptr_access),
    .next_o(ptr_next)
  );

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_ff <= PTR_RST;
    end else if (ptr_load_i) begin
      ptr_ff <= ptr_load_val_i;
    // Writes during a long write leave the pointer alone
    end else if (table_write_instr_i && state_ff == PMW_IDLE) begin
      ptr_ff <= ptr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start qualification
  assign odd_addr = ptr_access[ODD_BIT_POS];
  // Voltage qualifier sampled at the odd write, all six terms required
  assign start_long = table_write_instr_i && internal_target_i && state_ff == PMW_IDLE
                      && odd_addr && lwe_ff && reset_programming_pin_vpp_i;

  ////////////////////////////////////////////////////////////////////////////
  // Long write enable
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lwe_ff <= LWE_RST;
    end else if (lwe_set_i) begin
      lwe_ff <= 1'b1;  // Clear requests are deliberately ignored
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding register, internal only
  // External and odd writes never touch it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_ff <= HOLD_RST;
    end else if (table_write_instr_i && internal_target_i && state_ff == PMW_IDLE
                 && !odd_addr) begin
      hold_ff <= transfer_latch_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination
  // Flags and enables are levels; any enabled flag ends the write
  assign armed = irq_enable_i;
  assign fired = armed & irq_flag_i;
  assign end_long = state_ff == PMW_PROG && |fired;
  assign fired_high = |(fired & irq_high_prio_i);

  pmw_term_decode u_term (
    .high_priority_global_enable_i(high_priority_global_enable_i),
    .low_priority_global_enable_i(low_priority_global_enable_i),
    .high_prio_i(fired_high),
    .action_o(action_dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  // Only reset or an enabled flag leaves programming; no timer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PMW_IDLE: begin
        if (start_long) begin
          nxt_state = PMW_PROG;
        end
      end
      PMW_PROG: begin
        if (end_long) begin
          nxt_state = PMW_IDLE;
        end
      end
      default: begin
        nxt_state = PMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= PMW_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block address and data, high byte from latch, low from holding
  // Captured once at start so the array sees a steady block
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_ff <= PTR_RST;
      data_ff <= {HOLD_RST, HOLD_RST};
    end else if (start_long) begin
      addr_ff <= {ptr_access[PTR_W-1:1], 1'b0};
      data_ff <= {transfer_latch_i, hold_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination report; flags are never touched here
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      term_ff <= 1'b0;
      action_ff <= PMW_ACT_NONE;
    end else begin
      term_ff <= end_long;
      if (end_long) begin
        action_ff <= action_dec;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Halt and active come from the same state bit
  assign long_write_enable_o = lwe_ff;
  assign byte_pointer_o = ptr_ff;
  assign prog_active_o = state_ff == PMW_PROG;
  assign cpu_halt_o = state_ff == PMW_PROG;
  assign prog_addr_o = addr_ff;
  assign prog_data_o = data_ff;
  assign term_pulse_o = term_ff;
  assign term_action_o = action_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_lwe_sticky: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    lwe_ff |=> lwe_ff) else $error("long write enable cleared without reset");
  a_no_start_lwe: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && !lwe_ff) |=> state_ff == PMW_IDLE)
    else $error("long write started with enable clear");
  a_even_no_prog: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && table_write_instr_i && !odd_addr) |=> !prog_active_o)
    else $error("even write started programming");
  a_even_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && table_write_instr_i && internal_target_i && !odd_addr)
    |=> hold_ff == $past(transfer_latch_i)) else $error("holding register not loaded");
  a_odd_starts: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && table_write_instr_i && internal_target_i && odd_addr && lwe_ff
     && reset_programming_pin_vpp_i) |=> cpu_halt_o && prog_data_o[2*BYTE_W-1:BYTE_W]
    == $past(transfer_latch_i) && prog_data_o[BYTE_W-1:0] == $past(hold_ff))
    else $error("odd write did not start long write");
  a_no_vpp_no_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && !reset_programming_pin_vpp_i) |=> !cpu_halt_o)
    else $error("long write without programming voltage");
  a_disabled_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (prog_active_o && (irq_enable_i & irq_flag_i) == '0) |=> prog_active_o)
    else $error("long write ended without enabled flag");
  a_enabled_ends: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (prog_active_o && |(irq_enable_i & irq_flag_i)) |=> !prog_active_o ##0 term_pulse_o)
    else $error("enabled flag did not end long write");
  a_vec_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (end_long && high_priority_global_enable_i && !low_priority_global_enable_i
     && fired_high) |=> term_action_o == PMW_ACT_VEC_HIGH)
    else $error("high vector not chosen");
  a_vec_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (end_long && !high_priority_global_enable_i && low_priority_global_enable_i
     && !fired_high) |=> term_action_o == PMW_ACT_VEC_LOW)
    else $error("low vector not chosen");
  a_next_instr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (end_long && high_priority_global_enable_i == low_priority_global_enable_i)
    |=> term_action_o == PMW_ACT_NEXT) else $error("next instruction not chosen");
  a_ptr_post_inc: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (table_write_instr_i && !ptr_load_i && state_ff == PMW_IDLE
     && ptr_mode_i == PMW_PTR_POST_INC) |=> ptr_ff[PTR_LOW_W-1:0]
    == $past(ptr_ff[PTR_LOW_W-1:0]) + PTR_ONE && ptr_ff[PTR_W-1] == $past(ptr_ff[PTR_W-1]))
    else $error("pointer post increment wrong");

  // Pointer variants and load
  a_ptr_post_dec: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (table_write_instr_i && !ptr_load_i && state_ff == PMW_IDLE
     && ptr_mode_i == PMW_PTR_POST_DEC) |=> ptr_ff[PTR_LOW_W-1:0]
    == $past(ptr_ff[PTR_LOW_W-1:0]) - PTR_ONE) else $error("pointer post decrement wrong");
  a_ptr_pre_inc: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (table_write_instr_i && !ptr_load_i && state_ff == PMW_IDLE
     && ptr_mode_i == PMW_PTR_PRE_INC) |=> ptr_ff[PTR_LOW_W-1:0]
    == $past(ptr_ff[PTR_LOW_W-1:0]) + PTR_ONE) else $error("pointer pre increment wrong");
  a_ptr_keep: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (table_write_instr_i && !ptr_load_i && state_ff == PMW_IDLE
     && ptr_mode_i == PMW_PTR_KEEP) |=> $stable(ptr_ff)) else $error("pointer moved on keep");
  a_ptr_top_bit: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (table_write_instr_i && !ptr_load_i) |=> ptr_ff[PTR_W-1] == $past(ptr_ff[PTR_W-1]))
    else $error("pointer top bit changed by a write");
  a_ptr_load: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ptr_load_i |=> ptr_ff == $past(ptr_load_val_i))
    else $error("pointer load lost");
  a_halt_ptr_frozen: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (prog_active_o && !ptr_load_i) |=> $stable(ptr_ff))
    else $error("pointer moved during long write");

  // Holding register and enable bit
  a_ext_no_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && table_write_instr_i && !internal_target_i) |=> $stable(hold_ff))
    else $error("external write loaded holding register");
  a_odd_no_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (table_write_instr_i && odd_addr) |=> $stable(hold_ff))
    else $error("odd write loaded holding register");
  a_halt_hold_frozen: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    prog_active_o |=> $stable(hold_ff))
    else $error("holding register moved during long write");
  a_lwe_sets: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    lwe_set_i |=> lwe_ff)
    else $error("long write enable not set");
  a_lwe_clr_ignored: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (lwe_ff && lwe_clear_i) |=> lwe_ff)
    else $error("clear request dropped long write enable");
  a_ext_no_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && table_write_instr_i && !internal_target_i) |=> !prog_active_o)
    else $error("external write started programming");
  a_no_lwe_odd: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == PMW_IDLE && table_write_instr_i && odd_addr && !lwe_ff)
    |=> !prog_active_o && $stable(prog_data_o)) else $error("odd write without enable programmed");

  // Programming block and termination
  a_addr_even: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    prog_active_o |-> prog_addr_o[ODD_BIT_POS] == 1'b0)
    else $error("block address not even");
  a_block_stable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    prog_active_o |=> $stable(prog_data_o) && $stable(prog_addr_o))
    else $error("block changed during long write");
  a_disabled_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (prog_active_o && (irq_flag_i & ~irq_enable_i) != '0 && (irq_flag_i & irq_enable_i) == '0)
    |=> prog_active_o) else $error("disabled source ended long write");
  a_end_resumes: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    end_long |=> !cpu_halt_o && term_pulse_o)
    else $error("long write did not resume");
  a_term_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    term_pulse_o |=> !term_pulse_o)
    else $error("termination pulse longer than one cycle");
  a_action_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !end_long |=> $stable(term_action_o))
    else $error("termination action changed");
  a_next_mixed: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (end_long && ((!high_priority_global_enable_i && low_priority_global_enable_i && fired_high)
     || (high_priority_global_enable_i && !low_priority_global_enable_i && !fired_high)))
    |=> term_action_o == PMW_ACT_NEXT) else $error("mixed globals did not resume in place");

  c_short_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    table_write_instr_i && internal_target_i && !odd_addr && state_ff == PMW_IDLE);
  c_long_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i) start_long);
  c_term_next: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    end_long && action_dec == PMW_ACT_NEXT);
  c_term_vec: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    end_long && action_dec != PMW_ACT_NEXT);
  c_halt_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    prog_active_o && table_write_instr_i);
endmodule : pmw_block_writer
`default_nettype wire

// file: verification/pmw_mem_model.sv
// Program memory array model that captures each programmed block
`default_nettype none
module pmw_mem_model
  import pmw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic prog_active_i,
  input wire logic [pmw_pkg::PTR_W-1:0] prog_addr_i,
  input wire logic [2*pmw_pkg::BYTE_W-1:0] prog_data_i,
  output logic [pmw_pkg::PTR_W-1:0] read_addr_o,
  output logic [2*pmw_pkg::BYTE_W-1:0] read_data_o,
  output logic [7:0] blocks_o
);
  logic active_ff = 1'b0;
  initial begin
    read_addr_o = 22'h000000;
    read_data_o = 16'h0000;
    blocks_o = 8'h00;
  end
  // Whole block lands in the array when programming starts
  always @(posedge mclk_i) begin
    active_ff <= prog_active_i;
    if (prog_active_i && !active_ff) begin
      read_addr_o <= prog_addr_i;
      read_data_o <= prog_data_i;
      blocks_o <= blocks_o + 8'h01;
    end
  end
endmodule : pmw_mem_model
`default_nettype wire

// file: verification/program_memory_block_writer_tb_top.sv
// Testbench for the program memory block writer
`default_nettype none
module program_memory_block_writer_tb_top
  import pmw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_b_i, table_write_instr_i, internal_target_i, ptr_load_i;
  pmw_ptr_mode_t ptr_mode_i;
  logic [7:0] transfer_latch_i, irq_flag_i, irq_enable_i, irq_high_prio_i, mem_blocks;
  logic [21:0] ptr_load_val_i, byte_pointer_o, prog_addr_o, mem_addr;
  logic lwe_set_i, lwe_clear_i, reset_programming_pin_vpp_i;
  logic high_priority_global_enable_i, low_priority_global_enable_i;
  logic long_write_enable_o, cpu_halt_o, prog_active_o, term_pulse_o;
  logic [15:0] prog_data_o, mem_data;
  pmw_action_t term_action_o;
  int num_errors = 0;
  int checks_done = 0;
  logic [21:0] pexp [4] = '{22'h000100, 22'h000101, 22'h0000FF, 22'h000101};
  logic [2:0] cfg [5] = '{3'h3, 3'h4, 3'h2, 3'h5, 3'h6};
  pmw_action_t aexp [5] = '{PMW_ACT_NEXT, PMW_ACT_NEXT, PMW_ACT_VEC_LOW, PMW_ACT_VEC_HIGH,
    PMW_ACT_NEXT};

  pmw_block_writer dut_u (.mclk_i, .rst_b_i, .table_write_instr_i, .ptr_mode_i,
    .transfer_latch_i, .internal_target_i, .ptr_load_i, .ptr_load_val_i, .lwe_set_i,
    .lwe_clear_i, .reset_programming_pin_vpp_i, .irq_flag_i, .irq_enable_i,
    .irq_high_prio_i, .high_priority_global_enable_i, .low_priority_global_enable_i,
    .long_write_enable_o, .byte_pointer_o, .cpu_halt_o, .prog_active_o, .prog_addr_o,
    .prog_data_o, .term_pulse_o, .term_action_o);
  pmw_mem_model mem_u (.mclk_i, .prog_active_i(prog_active_o), .prog_addr_i(prog_addr_o),
    .prog_data_i(prog_data_o), .read_addr_o(mem_addr), .read_data_o(mem_data),
    .blocks_o(mem_blocks));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic done_t(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask : done_t
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic ld(input logic [21:0] v);
    @(posedge mclk_i);
    ptr_load_i <= 1'b1;
    ptr_load_val_i <= v;
    @(posedge mclk_i);
    ptr_load_i <= 1'b0;
  endtask : ld
  task automatic twr(input pmw_ptr_mode_t m, input logic [7:0] b, input logic intl);
    @(posedge mclk_i);
    ptr_mode_i <= m;
    transfer_latch_i <= b;
    internal_target_i <= intl;
    table_write_instr_i <= 1'b1;
    @(posedge mclk_i);
    table_write_instr_i <= 1'b0;
  endtask : twr
  task automatic no_halt();
    repeat (3) @(negedge mclk_i);
    cmp(24'(cpu_halt_o), 24'h0);
  endtask : no_halt
  task automatic long_wr(input logic [21:0] a, input logic [7:0] lo, input logic [7:0] hi);
    int i;
    ld(a);
    twr(PMW_PTR_POST_INC, lo, 1'b1);
    twr(PMW_PTR_KEEP, hi, 1'b1);
    for (i = 0; i < 4 && cpu_halt_o !== 1'b1; i++) @(negedge mclk_i);
    cmp(24'(cpu_halt_o), 24'h1);
    cmp(24'(prog_addr_o), 24'(a));
    cmp(24'(prog_data_o), 24'({hi, lo}));
    cmp(24'(prog_active_o), 24'h1);
  endtask : long_wr
  task automatic finish_wr(input pmw_action_t exp);
    int i;
    @(posedge mclk_i);
    irq_flag_i <= 8'h01;
    for (i = 0; i < 8 && term_pulse_o !== 1'b1; i++) @(negedge mclk_i);
    cmp(24'(term_pulse_o), 24'h1);
    cmp(24'(cpu_halt_o), 24'h0);
    cmp(24'(prog_active_o), 24'h0);
    cmp(24'(term_action_o), 24'(exp));
    @(posedge mclk_i);
    irq_flag_i <= 8'h00;
  endtask : finish_wr

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 4);
    num_errors++;
    conclude();
  end

  initial begin
    rst_b_i <= 1'b0;
    {table_write_instr_i, internal_target_i, ptr_load_i, lwe_set_i, lwe_clear_i} <= 5'h00;
    ptr_mode_i <= PMW_PTR_KEEP;
    transfer_latch_i <= 8'h00;
    ptr_load_val_i <= 22'h000000;
    reset_programming_pin_vpp_i <= 1'b0;
    {irq_flag_i, irq_enable_i, irq_high_prio_i} <= 24'h000000;
    {high_priority_global_enable_i, low_priority_global_enable_i} <= 2'h0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(negedge mclk_i);
    cmp(24'(long_write_enable_o), 24'h0);
    cmp(24'(byte_pointer_o), 24'h0);
    cmp(24'(term_action_o), 24'(PMW_ACT_NONE));
    done_t("reset");
    ld(22'h3FFFFF);
    twr(PMW_PTR_POST_INC, 8'h00, 1'b0);
    @(negedge mclk_i);
    cmp(24'(byte_pointer_o), 24'h200000);
    for (int i = 0; i < 4; i++) begin
      ld(22'h000100);
      twr(pmw_ptr_mode_t'(i), 8'h00, 1'b0);
      @(negedge mclk_i);
      cmp(24'(byte_pointer_o), 24'(pexp[i]));
    end
    done_t("pointer");
    @(posedge mclk_i);
    reset_programming_pin_vpp_i <= 1'b1;
    ld(22'h000040);
    twr(PMW_PTR_POST_INC, 8'h11, 1'b1);
    twr(PMW_PTR_KEEP, 8'h22, 1'b1);
    no_halt();
    @(posedge mclk_i);
    lwe_set_i <= 1'b1;
    @(posedge mclk_i);
    lwe_set_i <= 1'b0;
    lwe_clear_i <= 1'b1;
    @(posedge mclk_i);
    lwe_clear_i <= 1'b0;
    @(negedge mclk_i);
    cmp(24'(long_write_enable_o), 24'h1);
    @(posedge mclk_i);
    reset_programming_pin_vpp_i <= 1'b0;
    ld(22'h000041);
    twr(PMW_PTR_KEEP, 8'h33, 1'b1);
    no_halt();
    @(posedge mclk_i);
    reset_programming_pin_vpp_i <= 1'b1;
    ld(22'h000042);
    twr(PMW_PTR_KEEP, 8'h44, 1'b1);
    no_halt();
    done_t("qualifiers");
    @(posedge mclk_i);
    irq_enable_i <= 8'h01;
    long_wr(22'h000200, 8'hA5, 8'h5A);
    @(posedge mclk_i);
    irq_flag_i <= 8'h02;
    twr(PMW_PTR_POST_INC, 8'hFF, 1'b1);
    repeat (20) @(negedge mclk_i);
    cmp(24'(cpu_halt_o), 24'h1);
    cmp(24'(byte_pointer_o), 24'h000201);
    finish_wr(PMW_ACT_NEXT);
    cmp(24'(mem_data), 24'h005AA5);
    cmp(24'(mem_addr), 24'h000200);
    cmp(24'(mem_blocks), 24'h01);
    done_t("long write");
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      high_priority_global_enable_i <= cfg[i][2];
      low_priority_global_enable_i <= cfg[i][1];
      irq_high_prio_i <= {7'h00, cfg[i][0]};
      long_wr(22'h000300 + 22'(2 * i), 8'h10 + 8'(i), 8'hC0 + 8'(i));
      finish_wr(aexp[i]);
    end
    cmp(24'(mem_blocks), 24'h06);
    done_t("actions");
    long_wr(22'h000400, 8'h01, 8'h02);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    @(negedge mclk_i);
    cmp(24'(cpu_halt_o), 24'h0);
    cmp(24'(long_write_enable_o), 24'h0);
    @(posedge mclk_i);
    rst_b_i <= 1'b1;
    done_t("reset abort");
    conclude();
  end
endmodule : program_memory_block_writer_tb_top
`default_nettype wire
